// >>> inc/supervisor_pkg.sv
// Purpose: shared constants for the supply supervisor sequencer
// Assumes: 200 MHz system clock
// Notes: times kept in their own units, cycle counts derived
package supervisor_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned RESET_TIMEOUT_MS = 200;
	localparam int unsigned WATCHDOG_TIMEOUT_MS = 1600;
	localparam int unsigned GRACE_US = 18;
	localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int unsigned WATCHDOG_TIMEOUT_CYC = WATCHDOG_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int unsigned GRACE_CYC = GRACE_US * CLK_MHZ;
	localparam int unsigned CNT_W = 32;
	localparam logic RST_N_RESET_VAL = 1'b0;
	localparam logic CE_OUT_RESET_VAL = 1'b1;
	localparam logic WARN_N_RESET_VAL = 1'b0;
	typedef enum logic [1:0] {CE_BLOCKED, CE_PASS, CE_GRACE} ce_state_e;
endpackage : supervisor_pkg

// >>> src/sync_2ff.sv
// Purpose: two-flop synchroniser for one level
// Assumes: single clock sys_clk
// Notes: first flop read only by the second
`timescale 1ns/1ps
module sync_2ff #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Level
	input wire logic d,
	output logic q
);
	logic meta_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : sync_2ff

// >>> src/timeout_counter.sv
// Purpose: clearable up-counter flagging when a limit is reached
// Assumes: limit at least one
// Notes: saturates at the limit
`timescale 1ns/1ps
module timeout_counter #(
	parameter int unsigned LIMIT = 1,
	parameter int unsigned W = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Control
	input wire logic clear,
	input wire logic run,
	output logic done
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	localparam logic [W-1:0] LIM = W'(LIMIT);
	// A zero limit would flag at once, one beyond the width would truncate and flag early
	if (LIMIT < 1 || LIMIT > (2.0 ** W) - 1) begin : g_bad_limit
		$error("timeout_counter: LIMIT out of range");
	end
	assign cnt_next = clear ? '0 : (run && cnt_reg != LIM) ? cnt_reg + W'(1) : cnt_reg;
	assign done = (cnt_reg == LIM);
	always_ff @(posedge sys_clk) begin
		if (srst) cnt_reg <= '0;
		else cnt_reg <= cnt_next;
	end
endmodule : timeout_counter

// >>> src/supply_supervisor.sv
// Purpose: reset, low-line warning, backup switchover, watchdog and memory select gating
// Assumes: comparator flags and pins synchronous-ish levels, resynchronised here
// Notes: mid-supply kick level arrives as a separate floating flag
`timescale 1ns/1ps
// Behaviour
// - Supply below trip asserts reset
// - Reset held at least 200 ms
// - Renewed trip restarts the reset timeout
// - Active-high reset is complement, driven
// - No kick for 1.6 s forces reset
// - Reset or kick edge clears watchdog
// - Watchdog stopped during reset, runs after
// - Floating kick disables the watchdog
// - Warning output low on low-line trip
// - Backup needs below trip and below backup
// - Backup: high reset high, low reset and warning low
// - Backup: kick ignored, input floated
// - Backup: select output held high
// - Normal: select passes through
// - Reset blocks the select path, except a grace window already open at the trip
// - Trip during write: 18 us grace
// - Grace expiry forces select high
// - Host ending write ends gate immediately
// - Gate stays off once closed, until reset releases with no trip
// - Power-up: gate closed until reset releases
module supply_supervisor
	import supervisor_pkg::*;
#(
	parameter int unsigned RESET_CYC = RESET_TIMEOUT_CYC,
	parameter int unsigned WDOG_CYC = WATCHDOG_TIMEOUT_CYC,
	parameter int unsigned GRACE_CYCLES = GRACE_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Comparator flags
	input wire logic below_trip_in,
	input wire logic below_backup_in,
	input wire logic low_line_in,
	// Watchdog kick pin
	input wire logic kick_in,
	input wire logic kick_float_in,
	output logic kick_term_en,
	// Host reset and warning
	output logic reset_n,
	output logic reset_hi,
	output logic supply_warning_n,
	// Backup switch
	output logic backup_mode,
	// Memory select
	input wire logic ce_in_n,
	output logic ce_out_n,
	output logic ce_gate_on
);
	// ************************************************************
	// Parameter checks
	// ************************************************************
	// Every count must fit the shared counter width and be at least one
	localparam longint unsigned CNT_MAX = (64'h1 << CNT_W) - 64'h1;
	if (RESET_CYC < 1 || RESET_CYC > CNT_MAX) begin : g_bad_reset
		$error("supply_supervisor: RESET_CYC out of range");
	end
	if (WDOG_CYC < 1 || WDOG_CYC > CNT_MAX) begin : g_bad_wdog
		$error("supply_supervisor: WDOG_CYC out of range");
	end
	if (GRACE_CYCLES < 1 || GRACE_CYCLES > CNT_MAX) begin : g_bad_grace
		$error("supply_supervisor: GRACE_CYCLES out of range");
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Reset values stand for a supply still low, so nothing runs early
	logic trip_s, bak_s, low_s, kick_s, float_s, ce_s;
	sync_2ff #(.RESET_VAL(1'b1)) u_trip (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(below_trip_in),
		.q(trip_s)
	);
	sync_2ff #(.RESET_VAL(1'b0)) u_bak (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(below_backup_in),
		.q(bak_s)
	);
	sync_2ff #(.RESET_VAL(1'b1)) u_low (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(low_line_in),
		.q(low_s)
	);
	sync_2ff #(.RESET_VAL(1'b0)) u_kick (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(kick_in),
		.q(kick_s)
	);
	sync_2ff #(.RESET_VAL(1'b1)) u_flt (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(kick_float_in),
		.q(float_s)
	);
	// Select idles high, so the gate sees no write at start
	sync_2ff #(.RESET_VAL(1'b1)) u_ce (
		.sys_clk(sys_clk),
		.srst(srst),
		.d(ce_in_n),
		.q(ce_s)
	);

	// ************************************************************
	// Reset timeout
	// ************************************************************
	logic rst_active_reg, kick_prev_reg, wd_fire, rst_done;
	logic backup_w, kick_edge, wd_enabled, rst_clear, rst_next;
	assign backup_w = trip_s && bak_s;
	// Watchdog expiry restarts the timeout just like a fresh trip
	assign rst_clear = trip_s || wd_fire;
	timeout_counter #(.LIMIT(RESET_CYC), .W(CNT_W)) u_rst_tmr (
		.sys_clk(sys_clk),
		.srst(srst),
		.clear(rst_clear),
		.run(rst_active_reg),
		.done(rst_done)
	);
	assign rst_next = rst_clear ? 1'b1 : (rst_done ? 1'b0 : rst_active_reg);
	always_ff @(posedge sys_clk) begin
		if (srst) rst_active_reg <= 1'b1;
		else rst_active_reg <= rst_next;
	end

	// ************************************************************
	// Watchdog
	// ************************************************************
	// Kick edges are only meaningful outside backup, where the pin floats
	assign wd_enabled = !float_s && !backup_w;
	assign kick_edge = (kick_s != kick_prev_reg) && !rst_active_reg;
	logic wd_done;
	// Held clear through reset so the full period starts at release
	timeout_counter #(.LIMIT(WDOG_CYC), .W(CNT_W)) u_wd_tmr (
		.sys_clk(sys_clk),
		.srst(srst),
		.clear(rst_active_reg || kick_edge || !wd_enabled),
		.run(!rst_active_reg),
		.done(wd_done)
	);
	assign wd_fire = wd_done && wd_enabled && !rst_active_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) kick_prev_reg <= 1'b0;
		else kick_prev_reg <= kick_s;
	end

	// ************************************************************
	// Chip-select gate
	// ************************************************************
	ce_state_e ce_state_reg, ce_state_next;
	logic grace_done;
	timeout_counter #(.LIMIT(GRACE_CYCLES), .W(CNT_W)) u_gr_tmr (
		.sys_clk(sys_clk),
		.srst(srst),
		.clear(ce_state_reg != CE_GRACE),
		.run(1'b1),
		.done(grace_done)
	);
	always_comb begin
		ce_state_next = ce_state_reg;
		case (ce_state_reg)
			CE_BLOCKED: if (!rst_active_reg && !trip_s) ce_state_next = CE_PASS;
			CE_PASS: begin
				if (trip_s && !ce_s) ce_state_next = CE_GRACE;
				else if (rst_next) ce_state_next = CE_BLOCKED;
			end
			CE_GRACE: if (ce_s || grace_done) ce_state_next = CE_BLOCKED;
			default: ce_state_next = CE_BLOCKED;
		endcase
	end
	logic gate_next;
	assign gate_next = (ce_state_next != CE_BLOCKED) && !backup_w;
	logic ce_n_next, warn_n_next;
	assign ce_n_next = gate_next ? ce_s : 1'b1;
	assign warn_n_next = !(low_s || backup_w);
	always_ff @(posedge sys_clk) begin
		if (srst) ce_state_reg <= CE_BLOCKED;
		else ce_state_reg <= ce_state_next;
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reset_n <= RST_N_RESET_VAL;
			reset_hi <= !RST_N_RESET_VAL;
			supply_warning_n <= WARN_N_RESET_VAL;
			backup_mode <= 1'b0;
			kick_term_en <= 1'b0;
			ce_out_n <= CE_OUT_RESET_VAL;
			ce_gate_on <= 1'b0;
		end else begin
			reset_n <= !rst_next;
			reset_hi <= rst_next;
			supply_warning_n <= warn_n_next;
			backup_mode <= backup_w;
			kick_term_en <= backup_w;
			ce_gate_on <= gate_next;
			ce_out_n <= ce_n_next;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_reset_complement: assert property (@(posedge sys_clk) disable iff (srst) reset_hi == !reset_n)
		else $error("reset outputs not complementary");
	a_trip_resets: assert property (@(posedge sys_clk) disable iff (srst) trip_s |=> !reset_n)
		else $error("trip did not assert reset");
	a_reset_min: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(reset_n) |=> !reset_n [*8])
		else $error("reset released too early");
	a_backup_outs: assert property (@(posedge sys_clk) disable iff (srst)
		backup_w |=> reset_hi && !supply_warning_n && ce_out_n && kick_term_en)
		else $error("backup output levels wrong");
	a_warn_low: assert property (@(posedge sys_clk) disable iff (srst) low_s |=> !supply_warning_n)
		else $error("warning not asserted");
	a_wd_cleared: assert property (@(posedge sys_clk) disable iff (srst)
		rst_active_reg |=> !wd_done)
		else $error("watchdog not held clear during reset");
	a_float_off: assert property (@(posedge sys_clk) disable iff (srst)
		float_s |=> !wd_done)
		else $error("floating kick did not stop watchdog");
	a_gate_reset: assert property (@(posedge sys_clk) disable iff (srst)
		(rst_next && ce_state_next != CE_GRACE) |=> ce_out_n)
		else $error("select passed during reset");
	a_grace_end: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_reg == CE_GRACE && ce_s) |=> ce_out_n && ce_state_reg == CE_BLOCKED)
		else $error("gate not closed at write end");
	a_pass_thru: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_next == CE_PASS && !backup_w) |=> ce_out_n == $past(ce_s))
		else $error("select not passed");

	// ************************************************************
	// Check helper counters
	// ************************************************************
	// Saturating so a long idle stretch never wraps back to small values
	function automatic logic [CNT_W-1:0] sat_step(input logic [CNT_W-1:0] v);
		return (v == '1) ? v : v + CNT_W'(1);
	endfunction : sat_step
	logic [CNT_W-1:0] low_len_reg;
	logic [CNT_W-1:0] quiet_len_reg;
	logic [CNT_W-1:0] grace_len_reg;
	always_ff @(posedge sys_clk) begin
		if (srst || reset_n) low_len_reg <= '0;
		else low_len_reg <= sat_step(low_len_reg);
	end
	always_ff @(posedge sys_clk) begin
		if (srst || rst_active_reg || kick_edge || !wd_enabled) quiet_len_reg <= '0;
		else quiet_len_reg <= sat_step(quiet_len_reg);
	end
	always_ff @(posedge sys_clk) begin
		if (srst || ce_state_reg != CE_GRACE) grace_len_reg <= '0;
		else grace_len_reg <= sat_step(grace_len_reg);
	end

	// ************************************************************
	// Reset, watchdog and warning checks
	// ************************************************************
	a_low_len: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(reset_n) |-> low_len_reg >= CNT_W'(RESET_CYC))
		else $error("reset shorter than its timeout");
	a_trip_restart: assert property (@(posedge sys_clk) disable iff (srst)
		trip_s |=> !rst_done)
		else $error("trip did not restart reset timeout");
	a_wd_fire_rst: assert property (@(posedge sys_clk) disable iff (srst)
		wd_fire |=> !reset_n && reset_hi)
		else $error("watchdog expiry did not reset");
	a_quiet_limit: assert property (@(posedge sys_clk) disable iff (srst)
		wd_fire |-> quiet_len_reg >= CNT_W'(WDOG_CYC))
		else $error("watchdog fired early");
	a_wd_due: assert property (@(posedge sys_clk) disable iff (srst)
		(wd_enabled && !rst_active_reg && quiet_len_reg >= CNT_W'(WDOG_CYC)) |=> !reset_n)
		else $error("watchdog missed its expiry");
	a_kick_clears: assert property (@(posedge sys_clk) disable iff (srst)
		kick_edge |=> !wd_done)
		else $error("kick did not clear watchdog");
	a_warn_high: assert property (@(posedge sys_clk) disable iff (srst)
		(!low_s && !backup_w) |=> supply_warning_n)
		else $error("warning stuck low");

	// ************************************************************
	// Backup and gate checks
	// ************************************************************
	a_backup_mode: assert property (@(posedge sys_clk) disable iff (srst)
		1'b1 |=> backup_mode == $past(backup_w))
		else $error("backup flag wrong");
	a_kick_release: assert property (@(posedge sys_clk) disable iff (srst)
		1'b1 |=> kick_term_en == $past(backup_w))
		else $error("kick release wrong");
	a_backup_kick: assert property (@(posedge sys_clk) disable iff (srst)
		backup_w |=> !wd_done)
		else $error("kick counted in backup");
	a_ce_backup: assert property (@(posedge sys_clk) disable iff (srst)
		backup_w |=> !ce_gate_on)
		else $error("gate open in backup");
	a_pass_gate: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_next == CE_PASS && !backup_w) |=> ce_gate_on)
		else $error("gate closed in normal use");
	a_gate_closed: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_reg == CE_BLOCKED && ce_state_next == CE_BLOCKED) |=> ce_out_n && !ce_gate_on)
		else $error("closed gate passed select");
	a_grace_hold: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_reg == CE_GRACE && !ce_s && !backup_w && grace_len_reg < CNT_W'(GRACE_CYCLES)) |=> ce_gate_on)
		else $error("gate closed inside grace");
	a_grace_limit: assert property (@(posedge sys_clk) disable iff (srst)
		(ce_state_reg == CE_GRACE) |-> grace_len_reg <= CNT_W'(GRACE_CYCLES))
		else $error("grace outlived its window");
	a_gate_flag: assert property (@(posedge sys_clk) disable iff (srst)
		!ce_gate_on |-> ce_out_n)
		else $error("select low with gate off");
	a_powerup_shut: assert property (@(posedge sys_clk) disable iff (srst)
		(rst_active_reg && ce_state_reg == CE_BLOCKED) |=> !ce_gate_on)
		else $error("gate opened before reset release");
endmodule : supply_supervisor

// >>> dv/host_model.sv
// Purpose: host processor that kicks the supervisor watchdog
// Assumes: one kick every 40 clock cycles while it runs
// Notes: a floated kick pin is shown as a level changing each cycle
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic sys_clk,
	// Supervisor side
	input wire logic reset_n,
	input wire logic supply_warning_n,
	input wire logic kick_term_en,
	input wire logic kick_en,
	output logic kick_in
);
	logic [5:0] gap_reg = 6'h00;
	logic kick_reg = 1'b0;
	assign kick_in = kick_reg;
	always_ff @(posedge sys_clk) begin
		gap_reg <= (gap_reg == 6'h27) ? 6'h00 : gap_reg + 6'h01;
		if (kick_term_en) begin
			kick_reg <= ~kick_reg;
		end else if (kick_en && reset_n && supply_warning_n && gap_reg == 6'h27) begin
			// Warning means shutdown has begun, so no more kicks
			kick_reg <= ~kick_reg;
		end
	end
endmodule : host_model

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the supply supervisor
// Assumes: shortened counts 50, 200 and 20 cycles
// Notes: output latency of three edges allowed for
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic below_trip_in = 1'b0;
	logic below_backup_in = 1'b0;
	logic low_line_in = 1'b0;
	logic kick_float_in = 1'b0;
	logic kick_en = 1'b0;
	logic ce_in_n = 1'b0;
	logic kick_in, kick_term_en, reset_n, reset_hi, supply_warning_n, backup_mode, ce_out_n, ce_gate_on;
	int fails = 0;
	int tests_run = 0;
	int n;
	initial forever #2.5 sys_clk = ~sys_clk;
	supply_supervisor #(.RESET_CYC(50), .WDOG_CYC(200), .GRACE_CYCLES(20)) i_supply_supervisor (
		.sys_clk(sys_clk), .srst(srst), .below_trip_in(below_trip_in), .below_backup_in(below_backup_in),
		.low_line_in(low_line_in), .kick_in(kick_in), .kick_float_in(kick_float_in),
		.kick_term_en(kick_term_en), .reset_n(reset_n), .reset_hi(reset_hi),
		.supply_warning_n(supply_warning_n), .backup_mode(backup_mode), .ce_in_n(ce_in_n),
		.ce_out_n(ce_out_n), .ce_gate_on(ce_gate_on));
	host_model i_host_model (.sys_clk(sys_clk), .reset_n(reset_n), .supply_warning_n(supply_warning_n),
		.kick_term_en(kick_term_en), .kick_en(kick_en), .kick_in(kick_in));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic tally_and_finish();
		if (fails == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %b expected %b", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic wait_rst(input logic lvl, input int lim, output int k);
		k = 0;
		while (reset_n !== lvl && k < lim) begin
			cyc(1);
			k++;
			chk(reset_hi, ~reset_n);
		end
		if (k >= lim) begin
			fails++;
			tally_and_finish();
		end
	endtask : wait_rst
	task automatic quiet(input int len);
		repeat (len) begin
			cyc(1);
			chk(reset_n, 1'b1);
		end
	endtask : quiet
	task automatic t_powerup_wdog();
		cyc(3);
		chk(ce_out_n, 1'b1);
		chk(ce_gate_on, 1'b0);
		wait_rst(1'b1, 80, n);
		chk(n >= 48 && n <= 60, 1'b1);
		cyc(5);
		chk(ce_out_n, 1'b0);
		chk(ce_gate_on, 1'b1);
		wait_rst(1'b0, 260, n);
		// Count runs from five cycles after release
		chk(n + 5 >= 198 && n + 5 <= 210, 1'b1);
		chk(ce_out_n, 1'b1);
		chk(ce_gate_on, 1'b0);
		wait_rst(1'b1, 80, n);
		chk(n >= 48, 1'b1);
		@(posedge sys_clk) kick_en <= 1'b1;
		quiet(600);
		@(posedge sys_clk) kick_float_in <= 1'b1;
		kick_en <= 1'b0;
		quiet(600);
		@(posedge sys_clk) kick_float_in <= 1'b0;
		kick_en <= 1'b1;
	endtask : t_powerup_wdog
	task automatic t_warn();
		@(posedge sys_clk) low_line_in <= 1'b1;
		cyc(4);
		chk(supply_warning_n, 1'b0);
		chk(reset_n, 1'b1);
		@(posedge sys_clk) low_line_in <= 1'b0;
		cyc(4);
		chk(supply_warning_n, 1'b1);
	endtask : t_warn
	task automatic t_grace();
		@(posedge sys_clk) below_trip_in <= 1'b1;
		cyc(12);
		chk(ce_out_n, 1'b0);
		chk(reset_n, 1'b0);
		cyc(18);
		chk(ce_out_n, 1'b1);
		@(posedge sys_clk) below_trip_in <= 1'b0;
		wait_rst(1'b1, 90, n);
		cyc(5);
		@(posedge sys_clk) below_trip_in <= 1'b1;
		cyc(6);
		@(posedge sys_clk) ce_in_n <= 1'b1;
		cyc(4);
		chk(ce_out_n, 1'b1);
		@(posedge sys_clk) ce_in_n <= 1'b0;
		cyc(5);
		chk(ce_out_n, 1'b1);
		@(posedge sys_clk) below_trip_in <= 1'b0;
		cyc(30);
		@(posedge sys_clk) below_trip_in <= 1'b1;
		cyc(4);
		@(posedge sys_clk) below_trip_in <= 1'b0;
		wait_rst(1'b1, 90, n);
		chk(n >= 50, 1'b1);
	endtask : t_grace
	task automatic t_backup();
		@(posedge sys_clk) below_backup_in <= 1'b1;
		cyc(4);
		chk(backup_mode, 1'b0);
		@(posedge sys_clk) below_trip_in <= 1'b1;
		cyc(4);
		chk(backup_mode, 1'b1);
		chk(reset_hi, 1'b1);
		chk(reset_n, 1'b0);
		chk(supply_warning_n, 1'b0);
		chk(kick_term_en, 1'b1);
		chk(ce_out_n, 1'b1);
		@(posedge sys_clk) below_trip_in <= 1'b0;
		below_backup_in <= 1'b0;
		wait_rst(1'b1, 90, n);
	endtask : t_backup
	initial begin
		cyc(10);
		@(posedge sys_clk) srst <= 1'b0;
		t_powerup_wdog();
		t_warn();
		t_grace();
		t_backup();
		tally_and_finish();
	end
endmodule : tb_top
